// ==== design/swb_regs.vh ====
`ifndef SWB_REGS_VH
`define SWB_REGS_VH

// ----------------------------------------------------------------
// Burst-length field of mode_register_zero, bits 1:0
// ----------------------------------------------------------------
`define SWB_BL_FIXED8 2'b00
`define SWB_BL_OTF 2'b01
`define SWB_BL_CHOP4 2'b10

// ----------------------------------------------------------------
// Data-width configuration codes
// ----------------------------------------------------------------
`define SWB_CFG_X4 2'b00
`define SWB_CFG_X8 2'b01
`define SWB_CFG_X16 2'b10

// ----------------------------------------------------------------
// Beats per burst
// ----------------------------------------------------------------
`define SWB_BEATS_EIGHT 4'h8
`define SWB_BEATS_CHOP 4'h4

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define SWB_FIFO_DEPTH 8
`define SWB_BANKS 4
`define SWB_BANK_W 2
`define SWB_COL_W 4

`endif

// ==== design/swb_fifo.v ====
`timescale 1ns/10ps
module swb_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire doPush;
  wire doPop;

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = store[rdPtr_reg];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always @(posedge clk) begin
    if (doPush) begin
      store[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap explicitly so DEPTH need not be a power of two
  always @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        if (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) wrPtr_reg <= {AW{1'b0}};
        else wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        if (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) rdPtr_reg <= {AW{1'b0}};
        else rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (doPush & ~doPop) count_reg <= count_reg + 1'b1;
      else if (doPop & ~doPush) count_reg <= count_reg - 1'b1;
    end
  end

endmodule // swb_fifo

// ==== design/swb_write_burst.v ====
`timescale 1ns/10ps
`include "swb_regs.vh"
module swb_write_burst #(
  parameter NL = 2,
  parameter FIFO_DEPTH = `SWB_FIFO_DEPTH
) (
  input wire core_clk,
  input wire reset_n,
  input wire linkClk,
  input wire cmdWrite,
  input wire cmdActivate,
  input wire [`SWB_BANK_W-1:0] cmdBank,
  input wire cmdAddrA10,
  input wire cmdAddrA12,
  input wire [`SWB_COL_W-1:0] cmdColumn,
  input wire dataStrobe,
  input wire [8*NL-1:0] dataIn,
  input wire [NL-1:0] byteWriteMaskN,
  input wire [1:0] burstLenField,
  input wire [1:0] widthCfg,
  input wire maskEnable,
  input wire dbiEnable,
  input wire crcEnable,
  input wire [4:0] additiveLatency,
  input wire [4:0] casWriteLatency,
  input wire arrayStall,
  input wire overrunClear,
  input wire [`SWB_BANK_W+`SWB_COL_W-1:0] rdAddr,
  output wire fifoInReady,
  output reg [8*NL-1:0] rdData,
  output reg [`SWB_BANKS-1:0] bankOpen,
  output reg burstBusy,
  output reg burstIsChop,
  output reg autoPrecharge,
  output reg writeDone,
  output reg maskActive,
  output reg dbiActive,
  output reg configConflict,
  output reg crcPersistent,
  output reg crcNonPersistent,
  output reg beatOverrun
);

  localparam DW = 8 * NL;
  localparam AW = `SWB_BANK_W + `SWB_COL_W;
  localparam MW = AW + DW + NL;
  localparam PW = 5 + `SWB_BANK_W + `SWB_COL_W + 1 + DW + NL;
  localparam MEMD = `SWB_BANKS << `SWB_COL_W;
  localparam ST_IDLE = 2'b00;
  localparam ST_LAT = 2'b01;
  localparam ST_DATA = 2'b10;
  localparam ST_DONE = 2'b11;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses together so data and strobe keep their
  // relative timing; the bench must hold data two clocks around
  // each strobe edge.
  wire [PW-1:0] pinRaw;
  reg [PW-1:0] pinSync1_reg;
  reg [PW-1:0] pinSync2_reg;
  reg linkClkPrev_reg;
  reg strobePrev_reg;

  assign pinRaw = {linkClk, cmdWrite, cmdActivate, cmdAddrA10,
                   cmdAddrA12, cmdBank, cmdColumn, dataStrobe,
                   dataIn, byteWriteMaskN};

  // No reset here: the edge detectors keep following the pins through
  // reset, so a pin that idles high gives no false edge on release
  always @(posedge core_clk) begin
    pinSync1_reg <= pinRaw;
    pinSync2_reg <= pinSync1_reg;
    linkClkPrev_reg <= pinSync2_reg[PW-1];
    strobePrev_reg <= pinSync2_reg[DW+NL];
  end

  wire ckS;
  wire wrS;
  wire actS;
  wire a10S;
  wire a12S;
  wire [`SWB_BANK_W-1:0] bankS;
  wire [`SWB_COL_W-1:0] colS;
  wire strobeS;
  wire [DW-1:0] dqS;
  wire [NL-1:0] lanePinS;
  wire ckRise;
  wire strobeEdge;

  assign {ckS, wrS, actS, a10S, a12S, bankS, colS, strobeS, dqS,
          lanePinS} = pinSync2_reg;
  assign ckRise = ckS & ~linkClkPrev_reg;
  assign strobeEdge = strobeS ^ strobePrev_reg;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire burstEightSel;
  wire maskCapable;
  wire maskActiveNext;
  wire dbiActiveNext;
  wire [5:0] wlTotal;
  wire [5:0] wlOpen;

  // Reserved field code 11 is taken as fixed eight
  assign burstEightSel = (burstLenField == `SWB_BL_FIXED8) |
    (burstLenField == 2'b11) |
    ((burstLenField == `SWB_BL_OTF) & a12S);
  assign maskCapable = (widthCfg == `SWB_CFG_X8) |
    (widthCfg == `SWB_CFG_X16);
  // Conflicting setup disables both lane functions rather than
  // guessing which one software meant
  assign maskActiveNext = maskEnable & maskCapable & ~dbiEnable;
  assign dbiActiveNext = dbiEnable & ~maskEnable;
  assign wlTotal = {1'b0, additiveLatency} +
    {1'b0, casWriteLatency};
  assign wlOpen = (wlTotal == 6'h00) ? 6'h00 : wlTotal - 6'h01;

  always @(posedge core_clk) begin
    if (!reset_n) begin
      maskActive <= 1'b0;
      dbiActive <= 1'b0;
      configConflict <= 1'b0;
      crcPersistent <= 1'b0;
      crcNonPersistent <= 1'b0;
    end else begin
      maskActive <= maskActiveNext;
      dbiActive <= dbiActiveNext;
      configConflict <= maskEnable & dbiEnable;
      crcPersistent <= crcEnable & maskEnable;
      crcNonPersistent <= crcEnable & ~maskEnable;
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  // One write in flight: a write command seen while busy is ignored
  reg [1:0] state_reg;
  reg [5:0] latCount_reg;
  reg [3:0] beatCount_reg;
  reg [3:0] beatTarget_reg;
  reg [`SWB_BANK_W-1:0] burstBank_reg;
  reg [`SWB_COL_W-1:0] burstCol_reg;
  wire pushValid;
  wire pushReady;
  wire [`SWB_COL_W-1:0] beatCol;

  assign pushValid = (state_reg == ST_DATA) & strobeEdge;
  assign beatCol = burstCol_reg + beatCount_reg[`SWB_COL_W-1:0];

  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      latCount_reg <= 6'h00;
      beatCount_reg <= 4'h0;
      beatTarget_reg <= `SWB_BEATS_EIGHT;
      burstBank_reg <= {`SWB_BANK_W{1'b0}};
      burstCol_reg <= {`SWB_COL_W{1'b0}};
      burstBusy <= 1'b0;
      burstIsChop <= 1'b0;
      autoPrecharge <= 1'b0;
      writeDone <= 1'b0;
      bankOpen <= {`SWB_BANKS{1'b0}};
    end else begin
      writeDone <= 1'b0;
      if (ckRise & actS & ~wrS) begin
        bankOpen[bankS] <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (ckRise & wrS) begin
            burstBank_reg <= bankS;
            burstCol_reg <= colS;
            autoPrecharge <= a10S;
            burstIsChop <= ~burstEightSel;
            beatTarget_reg <= burstEightSel ? `SWB_BEATS_EIGHT :
              `SWB_BEATS_CHOP;
            latCount_reg <= 6'h00;
            beatCount_reg <= 4'h0;
            burstBusy <= 1'b1;
            if (wlOpen == 6'h00) state_reg <= ST_DATA;
            else state_reg <= ST_LAT;
          end
        end
        ST_LAT: begin
          if (ckRise) begin
            latCount_reg <= latCount_reg + 6'h01;
            if (latCount_reg + 6'h01 == wlOpen) begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (strobeEdge) begin
            beatCount_reg <= beatCount_reg + 4'h1;
            if (beatCount_reg + 4'h1 == beatTarget_reg) begin
              state_reg <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // Marks the end of the last beat for recovery timing
          writeDone <= 1'b1;
          burstBusy <= 1'b0;
          if (autoPrecharge) begin
            bankOpen[burstBank_reg] <= 1'b0;
          end
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-lane beat capture
  // ----------------------------------------------------------------
  wire [DW-1:0] beatData;
  wire [NL-1:0] beatKeep;

  genvar gl;
  generate
    for (gl = 0; gl < NL; gl = gl + 1) begin : gLane
      // Inverted lane restored when the shared pin flags inversion
      assign beatData[8*gl+7:8*gl] = dqS[8*gl+7:8*gl] ^
        {8{dbiActive & ~lanePinS[gl]}};
      // With masking active a low pin drops the lane; a high pin, or masking off, keeps it
      assign beatKeep[gl] = ~maskActive | lanePinS[gl];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Beat buffer
  // ----------------------------------------------------------------
  // The controller cannot be stalled, so a full buffer loses the
  // beat and raises a sticky flag instead
  wire popValid;
  wire popReady;
  wire [MW-1:0] popData;

  swb_fifo #(
    .WIDTH(MW),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) uBeatFifo (
    .clk(core_clk),
    .reset_n(reset_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData({burstBank_reg, beatCol, beatData, beatKeep}),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  assign fifoInReady = pushReady;
  assign popReady = ~arrayStall;

  always @(posedge core_clk) begin
    if (!reset_n) begin
      beatOverrun <= 1'b0;
    end else if (pushValid & ~pushReady) begin
      beatOverrun <= 1'b1;
    end else if (overrunClear) begin
      beatOverrun <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Memory array, one byte-wide bank per lane
  // ----------------------------------------------------------------
  wire [AW-1:0] popAddr;
  wire [DW-1:0] popLaneData;
  wire [NL-1:0] popKeep;
  wire arrayWrite;

  assign popAddr = popData[MW-1:DW+NL];
  assign popLaneData = popData[DW+NL-1:NL];
  assign popKeep = popData[NL-1:0];
  assign arrayWrite = popValid & popReady;

  generate
    for (gl = 0; gl < NL; gl = gl + 1) begin : gArray
      reg [7:0] laneMem [0:MEMD-1];
      always @(posedge core_clk) begin
        if (arrayWrite & popKeep[gl]) begin
          laneMem[popAddr] <= popLaneData[8*gl+7:8*gl];
        end
      end
      always @(posedge core_clk) begin
        if (!reset_n) begin
          rdData[8*gl+7:8*gl] <= 8'h00;
        end else begin
          rdData[8*gl+7:8*gl] <= laneMem[rdAddr];
        end
      end
    end
  endgenerate

endmodule // swb_write_burst

// ==== verification/swb_write_burst_asserts.sv ====
`timescale 1ns/10ps
`include "swb_regs.vh"
module swb_write_burst_asserts (
  input wire core_clk,
  input wire reset_n,
  input wire [1:0] widthCfg,
  input wire maskEnable,
  input wire dbiEnable,
  input wire crcEnable,
  input wire [`SWB_BANKS-1:0] bankOpen,
  input wire burstBusy,
  input wire burstIsChop,
  input wire autoPrecharge,
  input wire writeDone,
  input wire maskActive,
  input wire dbiActive,
  input wire configConflict,
  input wire crcPersistent,
  input wire crcNonPersistent
);
  // ----
  // Config outputs lag the pins by one edge
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire wide = widthCfg == `SWB_CFG_X8 || widthCfg == `SWB_CFG_X16;
  // Two edges out of reset before config outputs are trusted
  sequence up_s;
    reset_n ##1 reset_n;
  endsequence
  mask_cfg_a: assert property (up_s |=> maskActive ==
    $past(maskEnable && wide && !dbiEnable)) else $error("mask cfg");
  dbi_cfg_a: assert property (up_s |=> dbiActive ==
    $past(dbiEnable && !maskEnable)) else $error("dbi cfg");
  cfg_clash_a: assert property (up_s |=> configConflict ==
    $past(maskEnable && dbiEnable)) else $error("conflict");
  crc_pers_a: assert property (up_s |=> crcPersistent ==
    $past(crcEnable && maskEnable)) else $error("crc pers");
  crc_nonpers_a: assert property (up_s |=> crcNonPersistent ==
    $past(crcEnable && !maskEnable)) else $error("crc nonpers");
  done_pulse_a: assert property (writeDone |=> !writeDone)
    else $error("done pulse");
  done_busy_a: assert property (writeDone |-> $past(burstBusy))
    else $error("done busy");
  open_keep_a: assert property (writeDone && !autoPrecharge |->
    bankOpen == $past(bankOpen)) else $error("bank closed");
  chop_hold_a: assert property (burstBusy && $past(burstBusy) &&
    $past(burstBusy, 2) |-> $stable(burstIsChop)) else $error("chop");
endmodule // swb_write_burst_asserts
bind swb_write_burst swb_write_burst_asserts u_chk (.core_clk, .reset_n,
  .widthCfg, .maskEnable, .dbiEnable, .crcEnable, .bankOpen, .burstBusy,
  .burstIsChop, .autoPrecharge, .writeDone, .maskActive, .dbiActive,
  .configConflict, .crcPersistent, .crcNonPersistent);

// ==== verification/swb_ctl_model.sv ====
`timescale 1ns/10ps
module swb_ctl_model (
  output logic linkClk,
  output logic cmdWrite,
  output logic cmdActivate,
  output logic [1:0] cmdBank,
  output logic cmdAddrA10,
  output logic cmdAddrA12,
  output logic [3:0] cmdColumn,
  output logic dataStrobe,
  output logic [15:0] dataIn,
  output logic [1:0] byteWriteMaskN
);
  // ----
  // Controller side: free-running command clock
  // ----
  initial begin
    {cmdWrite, cmdActivate, cmdBank, cmdAddrA10, cmdAddrA12} = 6'h00;
    {cmdColumn, dataStrobe, dataIn, byteWriteMaskN} = 23'h000003;
    linkClk = 1'b0;
    forever #80 linkClk = ~linkClk;
  end
  task act(input logic [1:0] b);
    @(negedge linkClk);
    cmdBank = b;
    cmdActivate = 1'b1;
    @(negedge linkClk);
    cmdActivate = 1'b0;
  endtask
  task wr(input logic [1:0] b, input logic a10, input logic a12,
    input logic [3:0] c, input int wl, input logic [1:0] mk,
    input logic [7:0] s);
    int n;
    @(negedge linkClk);
    {cmdBank, cmdAddrA10, cmdAddrA12, cmdColumn} = {b, a10, a12, c};
    cmdWrite = 1'b1;
    byteWriteMaskN = mk;
    @(negedge linkClk);
    cmdWrite = 1'b0;
    {cmdAddrA10, cmdAddrA12} = ~{a10, a12};
    repeat (wl - 2) @(negedge linkClk);
    // Stray toggle just before the window must not count
    dataStrobe = ~dataStrobe;
    @(posedge linkClk);
    #80;
    // Eight toggles even for a chop, so extra beats are exercised
    for (n = 0; n < 8; n++) begin
      dataIn = {s ^ 8'(n), 8'ha0 + 8'(n)};
      #40;
      dataStrobe = ~dataStrobe;
      #40;
    end
    dataIn = ~dataIn;
    byteWriteMaskN = ~mk;
    @(posedge linkClk);
  endtask
endmodule // swb_ctl_model

// ==== verification/tb_swb_write_burst.sv ====
`timescale 1ns/10ps
`include "swb_regs.vh"
module tb_swb_write_burst;
  typedef struct packed {
    logic [1:0] bl; logic a12; logic a10; logic [1:0] bk; logic [3:0] cl;
    logic [4:0] al; logic [4:0] cas_write_latency; logic [1:0] wd;
    logic me; logic de; logic [1:0] mk; logic ch;
  } swb_row_t;
  // Never mask and inversion together in a row
  localparam swb_row_t ROWS [0:6] = '{
    '{2'h0,1'h0,1'h0,2'h0,4'h0,5'h00,5'h02,2'h1,1'h1,1'h0,2'h3,1'h0},
    '{2'h1,1'h0,1'h0,2'h0,4'h0,5'h00,5'h03,2'h1,1'h1,1'h0,2'h2,1'h1},
    '{2'h1,1'h1,1'h1,2'h1,4'hc,5'h00,5'h02,2'h2,1'h1,1'h0,2'h3,1'h0},
    '{2'h2,1'h1,1'h0,2'h1,4'hc,5'h01,5'h01,2'h1,1'h0,1'h0,2'h0,1'h1},
    '{2'h0,1'h0,1'h0,2'h2,4'h5,5'h0a,5'h09,2'h0,1'h1,1'h0,2'h0,1'h0},
    '{2'h0,1'h1,1'h0,2'h2,4'h5,5'h00,5'h02,2'h1,1'h0,1'h1,2'h1,1'h0},
    '{2'h3,1'h0,1'h0,2'h3,4'h8,5'h00,5'h02,2'h1,1'h0,1'h0,2'h3,1'h0}};
  logic core_clk, reset_n = 1'b0, maskEnable = 1'b0, dbiEnable = 1'b0;
  logic crcEnable = 1'b0, arrayStall = 1'b0, overrunClear = 1'b0;
  logic [1:0] burstLenField = 2'h0, widthCfg = 2'h1;
  logic [4:0] additiveLatency = 5'h00, casWriteLatency = 5'h02;
  logic [5:0] rdAddr = 6'h00;
  wire linkClk, cmdWrite, cmdActivate, cmdAddrA10, cmdAddrA12, dataStrobe;
  wire [1:0] cmdBank, byteWriteMaskN;
  wire [3:0] cmdColumn, bankOpen;
  wire [15:0] dataIn, rdData;
  wire fifoInReady, burstBusy, burstIsChop, autoPrecharge, writeDone;
  wire maskActive, dbiActive, configConflict, crcPersistent;
  wire crcNonPersistent, beatOverrun;
  int err_total = 0, comparisons = 0, cyc = 0, dones = 0, r, n, l, d0;
  swb_row_t rw;
  logic [15:0] q, e, v, prev [8];
  logic [7:0] s;
  logic [3:0] openExp;
  logic ma, da;
  swb_write_burst u_dut (.core_clk, .reset_n, .linkClk, .cmdWrite,
    .cmdActivate, .cmdBank, .cmdAddrA10, .cmdAddrA12, .cmdColumn,
    .dataStrobe, .dataIn, .byteWriteMaskN, .burstLenField, .widthCfg,
    .maskEnable, .dbiEnable, .crcEnable, .additiveLatency,
    .casWriteLatency, .arrayStall, .overrunClear, .rdAddr, .fifoInReady,
    .rdData, .bankOpen, .burstBusy, .burstIsChop, .autoPrecharge,
    .writeDone, .maskActive, .dbiActive, .configConflict, .crcPersistent,
    .crcNonPersistent, .beatOverrun);
  swb_ctl_model u_ctl (.linkClk, .cmdWrite, .cmdActivate, .cmdBank,
    .cmdAddrA10, .cmdAddrA12, .cmdColumn, .dataStrobe, .dataIn,
    .byteWriteMaskN);
  // ----
  // Clock, timeout and shared tasks
  // ----
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (writeDone === 1'b1) dones <= dones + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task results;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chkw(input logic [15:0] g, input logic [15:0] x);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task chkb(input logic g, input logic x);
    chkw({15'h0, g}, {15'h0, x});
  endtask
  task rd(input logic [5:0] a, output logic [15:0] o);
    @(negedge core_clk) rdAddr = a;
    @(negedge core_clk) o = rdData;
  endtask
  // Bounded wait; ends on a falling edge so drives stay off the clock
  task wait_done(input int c0);
    int k;
    for (k = 0; k < 3000 && dones == c0; k++) @(negedge core_clk);
    chkb(dones > c0, 1'b1);
  endtask
  task rst;
    @(negedge core_clk) reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chkb(burstBusy | beatOverrun, 1'b0);
    chkb(fifoInReady, 1'b1);
    chkw(16'(bankOpen), 16'h0);
    reset_n = 1'b1;
  endtask
  // ----
  // Row loop, then config, buffer and reset cases
  // ----
  initial begin
    rst();
    for (n = 0; n < 4; n++) u_ctl.act(2'(n));
    repeat (8) @(negedge core_clk);
    openExp = 4'hf;
    chkw(16'(bankOpen), 16'h000f);
    for (r = 0; r < 7; r++) begin
      rw = ROWS[r];
      s = 8'(8'h11 * (r + 1));
      @(negedge core_clk);
      {burstLenField, widthCfg, maskEnable, dbiEnable} =
        {rw.bl, rw.wd, rw.me, rw.de};
      {additiveLatency, casWriteLatency} = {rw.al, rw.cas_write_latency};
      for (n = 0; n < 8; n++) rd({rw.bk, 4'(rw.cl + n)}, prev[n]);
      d0 = dones;
      u_ctl.wr(rw.bk, rw.a10, rw.a12, rw.cl, rw.al + rw.cas_write_latency, rw.mk, s);
      wait_done(d0);
      ma = rw.me && rw.wd != `SWB_CFG_X4 && !rw.de;
      da = rw.de && !rw.me;
      chkb(burstIsChop, rw.ch);
      chkb(autoPrecharge, rw.a10);
      chkb(maskActive, ma);
      chkb(dbiActive, da);
      chkb(burstBusy, 1'b0);
      if (rw.a10) openExp[rw.bk] = 1'b0;
      chkw(16'(bankOpen), 16'(openExp));
      for (n = 0; n < 8; n++) begin
        rd({rw.bk, 4'(rw.cl + n)}, q);
        e = prev[n];
        v = {s ^ 8'(n), 8'ha0 + 8'(n)};
        if (n < (rw.ch ? 4 : 8)) for (l = 0; l < 2; l++)
          if (!(ma && !rw.mk[l]))
            e[l*8+:8] = (da && !rw.mk[l]) ? ~v[l*8+:8] : v[l*8+:8];
        chkw(q, e);
      end
    end
    {crcEnable, maskEnable, dbiEnable, widthCfg} = {3'h6, `SWB_CFG_X8};
    repeat (2) @(negedge core_clk);
    chkb(crcPersistent, 1'b1);
    maskEnable = 1'b0;
    repeat (2) @(negedge core_clk);
    chkb(crcNonPersistent & ~crcPersistent, 1'b1);
    {crcEnable, maskEnable, dbiEnable} = 3'h3;
    repeat (2) @(negedge core_clk);
    chkb(configConflict, 1'b1);
    chkb(maskActive | dbiActive, 1'b0);
    // Stalled drain: first burst fills the buffer, second overruns it
    {maskEnable, dbiEnable, arrayStall} = 3'h1;
    burstLenField = `SWB_BL_FIXED8;
    for (n = 0; n < 2; n++) begin
      d0 = dones;
      u_ctl.wr(2'h3, 1'b0, 1'b1, 4'h0, 2, 2'h3, 8'h77);
      wait_done(d0);
      chkb(n ? beatOverrun : fifoInReady, n ? 1'b1 : 1'b0);
    end
    arrayStall = 1'b0;
    repeat (20) @(negedge core_clk);
    chkb(fifoInReady & beatOverrun, 1'b1);
    overrunClear = 1'b1;
    repeat (2) @(negedge core_clk);
    chkb(beatOverrun, 1'b0);
    overrunClear = 1'b0;
    rst();
    results();
  end
endmodule // tb_swb_write_burst
